// *** rtl/aus_sync_slave.sv ***
// usart with synchronous slave shifter and wishbone register file
//
// Behaviour
// RL1 - async, sync master, sync slave modes selectable; only sync slave is built, other modes stay idle
// RL2 - software enables port and pin directions first
// RL3 - ninth bit marks address words
// RL4 - clock source bit clear selects slave
// RL5 - tx ninth-bit enable selects 9-bit transmit
// RL6 - transmit enable; receive enables override in sync
// RL7 - software sets sync, enable, clears clock source
// RL8 - software writes ninth bit before data
// RL9 - slave shifts on external clock pin
// RL10 - slave transmit equals master except sleep
// RL11 - second word waits; flag sets on handover
// RL12 - transmit flag with enable wakes core
// RL13 - software clears receive enables for transmit
// RL14 - holding register write starts transmission
// RL15 - slave ignores single receive enable
// RL16 - receive during sleep, buffer, wake
// RL17 - receive flag sets on word complete
// RL18 - rx ninth-bit enable selects 9-bit receive
// RL19 - software reads status before receive buffer
// RL20 - clearing continuous receive clears errors
// RL21 - software keeps parallel-port bits clear
// RL22 - transmit flag sets on holding handover
//
// Our own choice: register access over Wishbone.
`default_nettype none
module aus_sync_slave
	import aus_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// serial pins: clock in, data bidirectional
	input  wire logic        ck_pin_i,
	input  wire logic        dt_pin_i,
	output logic             dt_pin_o,
	output logic             dt_pin_oe_o,
	// core wake request
	output logic             wake_o
);
	aus_wb_req_t req;
	assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

	// registers
	logic [7:0] txstat_r, rxstat_r, txhold_r, rxbuf_r, ien_r, baud_r, iflag_r;
	logic       sleep_r, hold_full_r, ack_r, dt_o_r, dt_oe_r, wake_r;
	logic [31:0] dat_r;
	logic [8:0] tsr_r, rsr_r;
	logic [3:0] cnt_r;
	aus_state_t state_r;
	logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;

	// bus decode
	wire        acc    = req.cyc & req.stb & ~ack_r;
	// writes and read side effects land at the edge where the master sees ack,
	// so a register never changes before the cycle has been answered
	wire        taken  = req.cyc & req.stb & ack_r;
	wire        wr     = taken & req.we & req.sel[0];
	wire        rd     = taken & ~req.we;
	wire [7:0]  idx    = req.adr[9:2];
	wire [7:0]  wd     = req.dat[7:0];
	wire        wr_tx  = wr & (idx == IDX_TXHOLD);
	wire        wr_ts  = wr & (idx == IDX_TXSTAT);
	wire        wr_rs  = wr & (idx == IDX_RXSTAT);
	wire        wr_if  = wr & (idx == IDX_IFLAGS);
	wire        rd_rb  = rd & (idx == IDX_RXBUF);

	// mode decode
	wire serial_port_enable     = rxstat_r[RX_SERIAL_PORT_ENABLE];
	wire sync_m   = txstat_r[TX_SYNC];                        // see RL1
	wire slave_m  = sync_m & ~txstat_r[TX_CLOCK_SOURCE_SELECT];            // see RL4
	wire continuous_receive_enable     = rxstat_r[RX_CONTINUOUS_RECEIVE_ENABLE];
	wire rx_on    = serial_port_enable & slave_m & continuous_receive_enable;                   // see RL15
	wire tx_on    = serial_port_enable & slave_m & txstat_r[TX_TRANSMIT_ENABLE] & ~continuous_receive_enable; // see RL6
	wire nine_tx  = txstat_r[TX_TX9];                        // see RL5
	wire nine_rx  = rxstat_r[RX_RX9];                        // see RL18

	// external shift clock edges
	wire ck_rise  = ck_s2_r & ~ck_s3_r;                      // see RL9
	wire ck_fall  = ~ck_s2_r & ck_s3_r;

	// transmit handover
	wire tx_load  = (state_r == AUS_IDLE) & tx_on & hold_full_r; // see RL14
	wire tx_last  = (state_r == AUS_TX) & ck_fall & (cnt_r == CNT_ONE);
	// the last data bit only arrives at the final rising edge, so a word is
	// complete there; ending on a falling edge would lose that bit
	wire rx_done  = (state_r == AUS_RX) & ck_rise & (cnt_r == CNT_ONE);
	wire rx_start = (state_r == AUS_IDLE) & rx_on;
	wire [3:0] tx_bits = nine_tx ? BITS_9 : BITS_8;
	wire [3:0] rx_bits = nine_rx ? BITS_9 : BITS_8;
	wire [8:0] rsr_in  = nine_rx ? {dt_s2_r, rsr_r[8:1]} : {1'b0, dt_s2_r, rsr_r[7:1]};
	wire       overrun = rx_done & iflag_r[IF_RC];

	// read mux
	wire [7:0] rdv =
		(idx == IDX_IFLAGS)   ? iflag_r :
		(idx == IDX_RXSTAT)   ? rxstat_r :
		(idx == IDX_RXBUF)    ? rxbuf_r :
		(idx == IDX_IENABLES) ? ien_r :
		(idx == IDX_TXSTAT)   ? txstat_r :
		(idx == IDX_BAUDDIV)  ? baud_r :
		(idx == IDX_POWER)    ? {7'h00, sleep_r} : ZERO8;

	// transmit flag sets when holding register is empty
	wire transmit_flag_nxt = ~hold_full_r | tx_load;                  // see RL22

	// pin synchronisers
	always_ff @(posedge clk_i) begin
		ck_s1_r <= ck_pin_i;
		ck_s2_r <= ck_s1_r;
		ck_s3_r <= ck_s2_r;
		dt_s1_r <= dt_pin_i;
		dt_s2_r <= dt_s1_r;
	end

	// wishbone answer, one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			dat_r <= {24'h00_0000, rdv};
		end
	end

	// software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ien_r   <= ZERO8;
			baud_r  <= ZERO8;
			sleep_r <= 1'b0;
		end else if (wr & (idx == IDX_IENABLES)) begin
			ien_r <= wd;
		end else if (wr & (idx == IDX_BAUDDIV)) begin
			baud_r <= wd;
		end else if (wr & (idx == IDX_POWER)) begin
			sleep_r <= wd[0];
		end else if (wake_r) begin
			sleep_r <= 1'b0;
		end
	end

	// transmit status/control; empty status bit from shifter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txstat_r <= TXSTAT_RST;
		end else begin
			if (wr_ts)
				txstat_r <= (wd & TXSTAT_WMSK) | (txstat_r & ~TXSTAT_WMSK);
			txstat_r[TX_SHIFT_REGISTER_EMPTY] <= (state_r != AUS_TX) & ~tx_load;
		end
	end

	// receive status/control with error flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxstat_r <= ZERO8;
		end else begin
			if (wr_rs)
				rxstat_r[7:3] <= wd[7:3];
			if (wr_rs & ~wd[RX_CONTINUOUS_RECEIVE_ENABLE]) begin
				rxstat_r[RX_OVERRUN_ERROR] <= 1'b0;                   // see RL20
				rxstat_r[RX_FRAMING_ERROR] <= 1'b0;                   // see RL20
			end else if (overrun) begin
				rxstat_r[RX_OVERRUN_ERROR] <= 1'b1;
			end
			if (rx_done & ~overrun)
				rxstat_r[RX_R9D] <= nine_rx & rsr_in[8];     // see RL3
		end
	end

	// holding register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txhold_r    <= ZERO8;
			hold_full_r <= 1'b0;
		end else if (wr_tx) begin
			txhold_r    <= wd;
			hold_full_r <= 1'b1;
		end else if (tx_load) begin
			hold_full_r <= 1'b0;                             // see RL11
		end
	end

	// interrupt flags: hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			iflag_r <= ZERO8;
		end else begin
			if (wr_if)
				iflag_r <= (wd & IFLAG_WMSK) | (iflag_r & ~IFLAG_WMSK);
			iflag_r[IF_TX] <= transmit_flag_nxt;                      // see RL11
			if (rx_done)
				iflag_r[IF_RC] <= 1'b1;                      // see RL17
			else if (rd_rb)
				iflag_r[IF_RC] <= 1'b0;
		end
	end

	// shifter: transmit shifts on falling edge, receive samples on rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= AUS_IDLE;
			tsr_r   <= 9'h000;
			rsr_r   <= 9'h000;
			cnt_r   <= CNT_ZERO;
			rxbuf_r <= ZERO8;
			dt_o_r  <= 1'b0;
			dt_oe_r <= 1'b0;
		end else begin
			case (state_r)
				AUS_IDLE: begin
					dt_oe_r <= 1'b0;
					if (tx_load) begin
						state_r <= AUS_TX;                   // see RL10
						tsr_r   <= {txstat_r[TX_T9D], txhold_r};
						dt_o_r  <= txhold_r[0];
						dt_oe_r <= 1'b1;
						cnt_r   <= tx_bits;
					end else if (rx_start) begin
						state_r <= AUS_RX;                   // see RL16
						cnt_r   <= rx_bits;
					end
				end
				AUS_TX: begin
					if (~tx_on) begin
						state_r <= AUS_IDLE;
					end else if (ck_fall) begin
						tsr_r  <= {1'b0, tsr_r[8:1]};
						dt_o_r <= tsr_r[1];
						cnt_r  <= cnt_r - CNT_ONE;
						if (tx_last)
							state_r <= AUS_IDLE;
					end
				end
				AUS_RX: begin
					if (~rx_on) begin
						state_r <= AUS_IDLE;
					end else if (ck_rise) begin
						// sample and count on the same edge
						rsr_r <= rsr_in;
						cnt_r <= cnt_r - CNT_ONE;
						if (rx_done) begin
							state_r <= AUS_IDLE;
							if (~overrun)
								rxbuf_r <= rsr_in[7:0];      // see RL16
						end
					end
				end
				default: state_r <= AUS_IDLE;
			endcase
		end
	end

	// wake request while asleep on enabled flag
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wake_r <= 1'b0;
		else
			wake_r <= sleep_r & ((iflag_r[IF_TX] & ien_r[IF_TX])  // see RL12
				| (iflag_r[IF_RC] & ien_r[IF_RC]));               // see RL16
	end

	// outputs
	assign dat_o       = dat_r;
	assign ack_o       = ack_r;
	assign dt_pin_o    = dt_o_r;
	assign dt_pin_oe_o = dt_oe_r;
	assign wake_o      = wake_r;

	// assertions
	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held two cycles");
	chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o) else $error("ack missing");
	chk_slave_drive: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
		dt_pin_oe_o |-> (txstat_r[TX_SYNC] && !txstat_r[TX_CLOCK_SOURCE_SELECT])) else $error("drive outside slave");
	chk_rx_over_tx: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
		(continuous_receive_enable && state_r == AUS_IDLE) |=> !dt_pin_oe_o) else $error("tx despite receive");
	chk_load_start: assert property (@(posedge clk_i) disable iff (rst_i) // see RL14
		tx_load |=> (state_r == AUS_TX && dt_pin_oe_o && hold_full_r == $past(wr_tx))) else $error("load failed");
	chk_transmit_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
		(hold_full_r && state_r == AUS_TX && !tx_load && !wr_if) |=> !iflag_r[IF_TX]) else $error("flag early");
	chk_receive_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
		rx_done |=> iflag_r[IF_RC]) else $error("receive flag missing");
	chk_err_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see RL20
		(wr_rs && !wd[RX_CONTINUOUS_RECEIVE_ENABLE]) |=> !rxstat_r[RX_OVERRUN_ERROR] && !rxstat_r[RX_FRAMING_ERROR]) else $error("error kept");
	chk_wake_tx: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
		(sleep_r && iflag_r[IF_TX] && ien_r[IF_TX]) |=> wake_o) else $error("no wake");
	chk_nine_bits: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
		tx_load |=> cnt_r == $past(tx_bits)) else $error("bit count wrong");

	// transmit side: handover, bit order and line ownership
	// every check except chk_shift_register_empty_busy and chk_quiet_rx looks one edge past
	// its trigger, so a slipped register stage in the shifter shows up as a failure
	chk_hold_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL14
		wr_tx |=> hold_full_r)
		else $error("holding register not marked full");
	chk_first_bit: assert property (@(posedge clk_i) disable iff (rst_i) // see RL14
		tx_load |=> (dt_pin_o == $past(txhold_r[0])))
		else $error("first bit wrong");
	chk_tx_ninth: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
		(tx_load && nine_tx) |=> (tsr_r[8] == $past(txstat_r[TX_T9D])))
		else $error("ninth bit not loaded");
	chk_hold_wait: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
		(state_r == AUS_TX && hold_full_r) |=> hold_full_r)
		else $error("second word left early");
	chk_transmit_flag_handover: assert property (@(posedge clk_i) disable iff (rst_i) // see RL22
		(tx_load && !wr_tx) |=> iflag_r[IF_TX])
		else $error("transmit flag not set on handover");
	chk_shift_register_empty_busy: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
		(state_r == AUS_TX) |-> !txstat_r[TX_SHIFT_REGISTER_EMPTY])
		else $error("shift register shown empty while busy");
	chk_tx_shift: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
		(state_r == AUS_TX && tx_on && ck_fall && !tx_last) |=> (state_r == AUS_TX && dt_pin_o == $past(tsr_r[1])))
		else $error("bit not shifted on falling edge");
	chk_bit_steady: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
		(state_r == AUS_TX && tx_on && !ck_fall) |=> (dt_pin_o == $past(dt_pin_o)))
		else $error("bit moved without external clock");
	chk_abort_tx: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
		(state_r == AUS_TX && !tx_on) |=> (state_r == AUS_IDLE))
		else $error("transmit kept after disable");
	chk_quiet_rx: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
		(state_r == AUS_RX) |-> !dt_pin_oe_o)
		else $error("line driven while receiving");

	// receive side: word completion, ninth bit, overrun
	// a lost word must leave the buffer exactly as software last saw it
	chk_srx_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // see RL15
		(serial_port_enable && slave_m && !continuous_receive_enable) |=> (state_r != AUS_RX))
		else $error("receive without continuous enable");
	chk_rx_count: assert property (@(posedge clk_i) disable iff (rst_i) // see RL18
		rx_start |=> (cnt_r == $past(rx_bits)))
		else $error("receive bit count wrong");
	chk_rx_buffer: assert property (@(posedge clk_i) disable iff (rst_i) // see RL16
		(rx_done && !overrun) |=> (rxbuf_r == $past(rsr_in[7:0])))
		else $error("received word not buffered");
	chk_rx_ninth: assert property (@(posedge clk_i) disable iff (rst_i) // see RL18
		(rx_done && !overrun && nine_rx) |=> (rxstat_r[RX_R9D] == $past(dt_s2_r)))
		else $error("ninth receive bit wrong");
	chk_overrun_keep: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
		(rx_done && overrun) |=> (rxbuf_r == $past(rxbuf_r)))
		else $error("buffer overwritten on overrun");
	chk_overrun_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
		(overrun && !(wr_rs && !wd[RX_CONTINUOUS_RECEIVE_ENABLE])) |=> rxstat_r[RX_OVERRUN_ERROR])
		else $error("overrun not flagged");
	chk_receive_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
		(rd_rb && !rx_done) |=> !iflag_r[IF_RC])
		else $error("receive flag kept after read");

	// wake request: only while asleep, and sleep ends once it is seen
	chk_wake_rx: assert property (@(posedge clk_i) disable iff (rst_i) // see RL16
		(sleep_r && iflag_r[IF_RC] && ien_r[IF_RC]) |=> wake_o)
		else $error("no wake on receive");
	chk_wake_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
		!sleep_r |=> !wake_o)
		else $error("wake while awake");
	chk_sleep_end: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
		(wake_o && !wr) |=> !sleep_r)
		else $error("sleep kept after wake");
	cov_tx: cover property (@(posedge clk_i) tx_last);
	cov_rx: cover property (@(posedge clk_i) rx_done);
	cov_wake: cover property (@(posedge clk_i) wake_o);
	cov_over: cover property (@(posedge clk_i) overrun);
	cov_nine: cover property (@(posedge clk_i) tx_load && nine_tx);
endmodule // aus_sync_slave
`default_nettype wire

// *** rtl/aus_pkg.sv ***
// package for the addressable usart synchronous slave block
`default_nettype none
package aus_pkg;
	// register word addresses (printed offsets are indices, byte address = 4 * index)
	localparam logic [7:0] IDX_IFLAGS   = 8'h0C;
	localparam logic [7:0] IDX_RXSTAT   = 8'h18;
	localparam logic [7:0] IDX_TXHOLD   = 8'h19;
	localparam logic [7:0] IDX_RXBUF    = 8'h1A;
	localparam logic [7:0] IDX_IENABLES = 8'h8C;
	localparam logic [7:0] IDX_TXSTAT   = 8'h98;
	localparam logic [7:0] IDX_BAUDDIV  = 8'h99;
	localparam logic [7:0] IDX_POWER    = 8'hA0;
	// transmit status/control fields
	localparam int TX_CLOCK_SOURCE_SELECT = 7;
	localparam int TX_TX9  = 6;
	localparam int TX_TRANSMIT_ENABLE = 5;
	localparam int TX_SYNC = 4;
	localparam int TX_HIGH_BAUD_SELECT = 2;
	localparam int TX_SHIFT_REGISTER_EMPTY = 1;
	localparam int TX_T9D  = 0;
	// receive status/control fields
	localparam int RX_SERIAL_PORT_ENABLE  = 7;
	localparam int RX_RX9   = 6;
	localparam int RX_SINGLE_RECEIVE_ENABLE  = 5;
	localparam int RX_CONTINUOUS_RECEIVE_ENABLE  = 4;
	localparam int RX_ADDRESS_DETECT_ENABLE = 3;
	localparam int RX_FRAMING_ERROR  = 2;
	localparam int RX_OVERRUN_ERROR  = 1;
	localparam int RX_R9D   = 0;
	// interrupt flag/enable fields
	localparam int IF_PSP = 7;
	localparam int IF_RC  = 5;
	localparam int IF_TX  = 4;
	// reset values and masks
	localparam logic [7:0] TXSTAT_RST  = 8'h02;
	localparam logic [7:0] TXSTAT_WMSK = 8'hF5;
	localparam logic [7:0] RXSTAT_WMSK = 8'hF8;
	localparam logic [7:0] IFLAG_WMSK  = 8'h4F;
	localparam logic [7:0] ZERO8       = 8'h00;
	localparam logic [3:0] CNT_ZERO    = 4'h0;
	localparam logic [3:0] CNT_ONE     = 4'h1;
	localparam logic [3:0] BITS_8      = 4'h8;
	localparam logic [3:0] BITS_9      = 4'h9;
	// shifter state
	typedef enum logic [1:0] {AUS_IDLE, AUS_TX, AUS_RX} aus_state_t;
	// wishbone request carrier
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] sel;
		logic [9:0] adr;
		logic [31:0] dat;
	} aus_wb_req_t;
endpackage
`default_nettype wire

// *** verif/aus_ck_master.sv ***
// external shift clock master that faces the slave port
`default_nettype none
module aus_ck_master (
	// link pins
	output var logic ck_o,
	output var logic dt_o,
	input  wire logic dt_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock stands high between frames
	initial begin
		ck_o = 1'b1;
		dt_o = 1'b0;
	end

	// one frame, lsb first: data moves after the fall; the slave samples at the rise, this task reads dt_i just before each fall
	task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = 9'h000;
		for (int i = 0; i < n; i++) begin
			rx[i] = dt_i;
			ck_o = 1'b0;
			#10 dt_o = tx[i];
			#52.5 ck_o = 1'b1;
			#62.5;
		end
		dt_o = ~dt_o; // released line shows the inverse of its last value
	endtask
endmodule // aus_ck_master
`default_nettype wire

// *** verif/aus_sync_slave_bench.sv ***
// self-checking bench for the synchronous slave usart
`default_nettype none
module aus_sync_slave_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import aus_pkg::*;

	logic        clk_i;
	logic        rst_i;
	aus_wb_req_t req;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        dt_o;
	logic        dt_oe;
	logic        wake_o;
	wire  logic  ck;
	wire  logic  p_dt;
	wire  logic  dt_w;
	logic [31:0] rnd;
	logic [31:0] r;
	logic [8:0]  got;
	int          failures;
	int          total_checks;
	logic        wake_d;
	int          wakes = 0;

	// count wake pulses; the request only lasts until sleep ends
	always @(posedge clk_i) begin
		wake_d <= wake_o;
		if (wake_o === 1'b1 && wake_d !== 1'b1)
			wakes++;
	end

	// data wire: the device wins while it drives
	assign dt_w = dt_oe ? dt_o : p_dt;

	aus_sync_slave DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb), .we_i(req.we),
		.sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat), .dat_o(dat_o), .ack_o(ack_o),
		.ck_pin_i(ck), .dt_pin_i(dt_w), .dt_pin_o(dt_o), .dt_pin_oe_o(dt_oe), .wake_o(wake_o)
	);

	aus_ck_master P (.ck_o(ck), .dt_o(p_dt), .dt_i(dt_w));

	// random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// word expected on the wire
	function automatic logic [8:0] exp_word(input logic [7:0] d, input logic n9, input int k);
		return (k != 0) ? {n9, d} : {1'b0, d};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, 4'hF, {idx, 2'h0}, {24'h000000, wd}};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		if (n >= 50) check("ack", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d, r);
	endtask

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00, r);
		check(nm, r, {24'h000000, e});
	endtask

	task automatic complete_run();
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// watchdog
	initial begin
		#200000;
		failures++;
		complete_run();
	end

	// main sequence
	initial begin
		rst_i = 1'b1;
		req = '0;
		rnd = 32'hD3CA;
		failures = 0;
		total_checks = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk("txstat", IDX_TXSTAT, TXSTAT_RST);
		rchk("rxstat", IDX_RXSTAT, ZERO8);
		rchk("iflags", IDX_IFLAGS, 8'h10);
		rchk("ienables", IDX_IENABLES, ZERO8);
		rnd = lfsr(rnd);
		wr(IDX_BAUDDIV, rnd[7:0]);
		wr(8'h55, rnd[15:8]);
		rchk("bauddiv", IDX_BAUDDIV, rnd[7:0]);
		rchk("unmapped", 8'h55, ZERO8);
		// two words back to back, 8 bits on the first pass, 9 bits on the second
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			wr(IDX_RXSTAT, 8'h80);
			wr(IDX_TXSTAT, {1'b0, k[0], 5'h18, rnd[16]});
			wr(IDX_TXHOLD, rnd[7:0]);
			wr(IDX_TXHOLD, rnd[15:8]);
			rchk("tx flag held", IDX_IFLAGS, ZERO8);
			P.frame(9'h000, 8 + k, got);
			check("word 1", got, exp_word(rnd[7:0], rnd[16], k));
			repeat (8) @(posedge clk_i);
			rchk("tx flag", IDX_IFLAGS, 8'h10);
			P.frame(9'h000, 8 + k, got);
			check("word 2", got, exp_word(rnd[15:8], rnd[16], k));
			repeat (8) @(posedge clk_i);
			check("oe idle", dt_oe, 32'h0);
		end
		// receive while asleep, single receive enable set as well
		wr(IDX_TXSTAT, 8'h50);
		wr(IDX_IENABLES, 8'h20);
		wr(IDX_RXSTAT, 8'hF0);
		wr(IDX_POWER, 8'h01);
		rnd = lfsr(rnd);
		P.frame(rnd[8:0], 9, got);
		repeat (8) @(posedge clk_i);
		check("wake", wakes, 32'h1);
		rchk("sleep ended", IDX_POWER, ZERO8);
		rchk("rx flag", IDX_IFLAGS, 8'h30);
		rchk("rx status", IDX_RXSTAT, {7'h78, rnd[8]});
		rchk("rx data", IDX_RXBUF, rnd[7:0]);
		rchk("rx flag clear", IDX_IFLAGS, 8'h10);
		// receive enable overrides transmit, then overrun
		wr(IDX_TXSTAT, 8'h30);
		wr(IDX_TXHOLD, 8'hA5);
		repeat (4) @(posedge clk_i);
		check("tx refused", dt_oe, 32'h0);
		P.frame(rnd[24:16], 9, got);
		P.frame(rnd[17:9], 9, got);
		repeat (8) @(posedge clk_i);
		wb(1'b0, IDX_RXSTAT, 8'h00, r);
		check("overrun", r[7:1], 32'h79);
		rchk("kept word", IDX_RXBUF, rnd[23:16]);
		wr(IDX_RXSTAT, 8'hE0);
		wb(1'b0, IDX_RXSTAT, 8'h00, r);
		check("error cleared", r[2:1], 32'h0);
		// transmit flag wakes the core once sleep is entered with its enable set
		wr(IDX_IENABLES, 8'h10);
		wr(IDX_POWER, 8'h01);
		repeat (8) @(posedge clk_i);
		check("tx wake", wakes, 32'h2);
		rchk("tx sleep ended", IDX_POWER, ZERO8);
		complete_run();
	end
endmodule // aus_sync_slave_bench
`default_nettype wire
